// ---- design/ryc_pkg.sv ----
// Purpose: shared constants for the year/century count and alarm set-point block
// Assumes: APB slave, word per register, byte address = 4 * index
// Notes:   indexes below e6..ef are register indexes, not byte addresses
package ryc_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    // register indexes; byte address is four times these
    localparam logic [9:0]  IDX_YEAR        = 10'h0e6;
    localparam logic [9:0]  IDX_HUNDRED     = 10'h0e7;
    localparam logic [9:0]  IDX_ALARM_SECOND_UNITS        = 10'h0e8;
    localparam logic [9:0]  IDX_ALARM_MINUTE_UNITS        = 10'h0e9;
    localparam logic [9:0]  IDX_AHOUR       = 10'h0ea;
    localparam logic [9:0]  IDX_AWDAY       = 10'h0eb;
    localparam logic [9:0]  IDX_AENABLE     = 10'h0ec;
    localparam logic [9:0]  IDX_CONTROL     = 10'h0ed;
    localparam logic [9:0]  IDX_STATUS      = 10'h0ee;
    localparam logic [9:0]  IDX_MASK        = 10'h0ef;
    // control register fields
    localparam int          CTL_UNLOCK_BIT  = 0;
    localparam int          CTL_DECIMAL_BIT = 5;
    // alarm enable fields
    localparam int          EN_SEC_BIT      = 0;
    localparam int          EN_MIN_BIT      = 1;
    localparam int          EN_HOUR_BIT     = 2;
    localparam int          EN_WDAY_BIT     = 3;
    // status / mask fields
    localparam int          ST_ALARM_BIT    = 0;
    localparam int          ST_WIDTH        = 1;
    // values after reset
    localparam logic [3:0]  AENABLE_RST     = 4'h0;
    localparam logic        UNLOCK_RST      = 1'h0;
    localparam logic        DECIMAL_RST     = 1'h0;
    localparam logic [0:0]  MASK_RST        = 1'h0;
    // count limits
    localparam logic [7:0]  BIN_YEAR_MAX    = 8'h63;
    localparam logic [3:0]  DIGIT_MAX       = 4'h9;
endpackage : ryc_pkg

// ---- design/ryc_regs.sv ----
// Purpose: year and hundred-year counts plus alarm set-points, APB reachable
// Assumes: pclk 10 MHz, inputs synchronous to pclk, live time fields from neighbours
// Notes:   one access-phase wait state; alarm flag is sticky, cleared by status read
//
// How it works
// - year count kept across reset, mode-dependent
// - year/hundred writes only while unlocked
// - decimal year: tens high, ones low
// - binary year: zero to ninety-nine
// - hundred-year count kept across reset
// - decimal hundred-year: tens high, ones low
// - binary hundred-year: zero to ninety-nine
// - alarm seconds kept across reset, decimal fields
// - binary alarm seconds up to fifty-nine
// - alarm minutes kept, decimal or binary
// - alarm hours kept, decimal or binary
// - alarm sec/min/hour always writable
// - weekday low nibble, upper reads zero
// - weekday nibble writable only while unlocked
// - decimal select switches all encodings together
// - unlock permits writes and stops counting
// - alarm evaluated on lock or count tick
// - per-field alarm enables, reset disabled
//
// Local design decision: the APB slave port.
module ryc_regs
(
    // clock, reset, freeze
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // live time fields from the neighbouring counters
    input  wire logic [7:0]  cur_second,
    input  wire logic [7:0]  cur_minute,
    input  wire logic [7:0]  cur_hour,
    input  wire logic [3:0]  cur_weekday,
    input  wire logic        count_tick,
    input  wire logic        year_carry,
    // to the neighbours
    output logic             decimal_select,
    output logic             count_unlock,
    output logic [3:0]       alarm_enable,
    output logic [7:0]       year_count,
    output logic [7:0]       hundred_year_count,
    output logic             alarm_flag,
    output logic             alarm_irq
);
    // storage
    logic [7:0]  year_r;
    logic [7:0]  hundred_r;
    logic [7:0]  alarm_second_units_r;
    logic [7:0]  alarm_minute_units_r;
    logic [7:0]  ahour_r;
    logic [3:0]  awday_r;
    logic [3:0]  aenable_r;
    logic        unlock_r;
    logic        decimal_r;
    logic [0:0]  status_r;
    logic [0:0]  mask_r;
    logic        ready_r;
    logic [31:0] rdata_r;
    logic        slverr_r;
    logic        irq_r;

    // bus decode
    logic [9:0]  idx;
    logic        done;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [7:0]  wb;
    logic [31:0] rd_nxt;

    // counting helpers
    logic        year_wrap;
    logic [7:0]  year_nxt;
    logic [7:0]  hundred_nxt;
    logic        alarm_eval;
    logic        alarm_hit;
    logic [0:0]  status_nxt;

    assign idx  = paddr[11:2];
    assign done = pclk_en && psel && penable && ready_r;
    assign wr   = done && pwrite && pstrb[0] && mapped;
    assign rd   = done && !pwrite;
    assign wb   = pwdata[7:0];

    always_comb
    begin
        mapped = (paddr[1:0] == 2'h0) && (idx >= ryc_pkg::IDX_YEAR)
                 && (idx <= ryc_pkg::IDX_MASK);
    end

    // increment a two-digit count in the selected encoding; wraps past 99
    function automatic logic [8:0] step99(input logic [7:0] v, input logic dec);
        logic [8:0] r;
        r = 9'h000;
        if (dec)
        begin
            if (v[3:0] >= ryc_pkg::DIGIT_MAX)
            begin
                if (v[7:4] >= ryc_pkg::DIGIT_MAX)
                    r = {1'h1, 8'h00};
                else
                    r = {1'h0, v[7:4] + 4'h1, 4'h0};
            end
            else
                r = {1'h0, v[7:4], v[3:0] + 4'h1};
        end
        else
        begin
            if (v >= ryc_pkg::BIN_YEAR_MAX)
                r = {1'h1, 8'h00};
            else
                r = {1'h0, v + 8'h01};
        end
        return r;
    endfunction : step99

    always_comb
    begin
        {year_wrap, year_nxt} = step99(year_r, decimal_r);
        // its own wrap is dropped: the hundred-year count simply rolls over
        hundred_nxt = 8'(step99(hundred_r, decimal_r));
    end

    // apb answer: one wait state, then data and error together
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_r  <= 1'h0;
            slverr_r <= 1'h0;
            rdata_r  <= 32'h0000_0000;
        end
        else if (pclk_en)
        begin
            ready_r  <= psel && penable && !ready_r;
            slverr_r <= psel && penable && !ready_r && !mapped;
            rdata_r  <= (psel && penable && !ready_r && !pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (idx)
            ryc_pkg::IDX_YEAR:    rd_nxt[7:0] = year_r;
            ryc_pkg::IDX_HUNDRED: rd_nxt[7:0] = hundred_r;
            ryc_pkg::IDX_ALARM_SECOND_UNITS:    rd_nxt[7:0] = alarm_second_units_r;
            ryc_pkg::IDX_ALARM_MINUTE_UNITS:    rd_nxt[7:0] = alarm_minute_units_r;
            ryc_pkg::IDX_AHOUR:   rd_nxt[7:0] = ahour_r;
            ryc_pkg::IDX_AWDAY:   rd_nxt[7:0] = {4'h0, awday_r};
            ryc_pkg::IDX_AENABLE: rd_nxt[3:0] = aenable_r;
            ryc_pkg::IDX_CONTROL:
            begin
                rd_nxt[ryc_pkg::CTL_UNLOCK_BIT]  = unlock_r;
                rd_nxt[ryc_pkg::CTL_DECIMAL_BIT] = decimal_r;
            end
            ryc_pkg::IDX_STATUS:  rd_nxt[0:0] = status_r;
            ryc_pkg::IDX_MASK:    rd_nxt[0:0] = mask_r;
            default:              rd_nxt = 32'h0000_0000;
        endcase
        if (!mapped)
            rd_nxt = 32'h0000_0000;
    end

    // year and hundred-year counts: no reset, so time survives it
    always_ff @(posedge pclk)
    begin
        if (pclk_en)
        begin
            if (wr && unlock_r && idx == ryc_pkg::IDX_YEAR)
                year_r <= wb;
            else if (year_carry && !unlock_r)
                year_r <= year_nxt;
            if (wr && unlock_r && idx == ryc_pkg::IDX_HUNDRED)
                hundred_r <= wb;
            else if (year_carry && !unlock_r && year_wrap)
                hundred_r <= hundred_nxt;
        end
    end

    // set-points: no reset; sec/min/hour ignore the lock
    always_ff @(posedge pclk)
    begin
        if (pclk_en && wr)
        begin
            if (idx == ryc_pkg::IDX_ALARM_SECOND_UNITS)
                alarm_second_units_r <= wb;
            if (idx == ryc_pkg::IDX_ALARM_MINUTE_UNITS)
                alarm_minute_units_r <= wb;
            if (idx == ryc_pkg::IDX_AHOUR)
                ahour_r <= wb;
            if (idx == ryc_pkg::IDX_AWDAY && unlock_r)
                awday_r <= wb[3:0];
        end
    end

    // control: decimal select, unlock, alarm enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlock_r  <= ryc_pkg::UNLOCK_RST;
            decimal_r <= ryc_pkg::DECIMAL_RST;
            aenable_r <= ryc_pkg::AENABLE_RST;
            mask_r    <= ryc_pkg::MASK_RST;
        end
        else if (pclk_en && wr)
        begin
            if (idx == ryc_pkg::IDX_CONTROL)
            begin
                unlock_r  <= wb[ryc_pkg::CTL_UNLOCK_BIT];
                decimal_r <= wb[ryc_pkg::CTL_DECIMAL_BIT];
            end
            if (idx == ryc_pkg::IDX_AENABLE)
                aenable_r <= wb[3:0];
            if (idx == ryc_pkg::IDX_MASK)
                mask_r <= wb[0:0];
        end
    end

    // evaluation only on relock or a counting tick, so a half-edited
    // time cannot raise a stray alarm
    always_comb
    begin
        alarm_eval = (wr && idx == ryc_pkg::IDX_CONTROL && unlock_r
                      && !wb[ryc_pkg::CTL_UNLOCK_BIT])
                     || (count_tick && !unlock_r);
        alarm_hit = (aenable_r != 4'h0)
            && (!aenable_r[ryc_pkg::EN_SEC_BIT]  || alarm_second_units_r  == cur_second)
            && (!aenable_r[ryc_pkg::EN_MIN_BIT]  || alarm_minute_units_r  == cur_minute)
            && (!aenable_r[ryc_pkg::EN_HOUR_BIT] || ahour_r == cur_hour)
            && (!aenable_r[ryc_pkg::EN_WDAY_BIT] || awday_r == cur_weekday);
        status_nxt = status_r;
        if (rd && idx == ryc_pkg::IDX_STATUS && mapped)
            status_nxt = 1'h0;
        if (alarm_eval && alarm_hit) // set wins over read-clear
            status_nxt[ryc_pkg::ST_ALARM_BIT] = 1'h1;
    end

    // sticky alarm status and masked interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= 1'h0;
            irq_r    <= 1'h0;
        end
        else if (pclk_en)
        begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & mask_r);
        end
    end

    // outputs straight from flops
    assign prdata             = rdata_r;
    assign pready             = ready_r;
    assign pslverr            = slverr_r;
    assign decimal_select     = decimal_r;
    assign count_unlock       = unlock_r;
    assign alarm_enable       = aenable_r;
    assign year_count         = year_r;
    assign hundred_year_count = hundred_r;
    assign alarm_flag         = status_r[ryc_pkg::ST_ALARM_BIT];
    assign alarm_irq          = irq_r;
endmodule : ryc_regs

// ---- dv/ryc_regs_checker.sv ----
// Purpose: apb timing and alarm checks for ryc_regs
// Assumes: pclk_en held high by the bench
// Notes:   year checks start once software has written the year
module ryc_regs_checker
(
    // clock, reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // time and alarm
    input wire logic        count_tick,
    input wire logic        year_carry,
    input wire logic        count_unlock,
    input wire logic [3:0]  alarm_enable,
    input wire logic [7:0]  year_count,
    input wire logic        alarm_flag,
    input wire logic        alarm_irq
);
    logic [7:0] w_lo;
    assign w_lo = pwdata[7:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_s(logic [9:0] i);
        psel && penable && pready && pwrite && pstrb[0] && paddr == {i, 2'b00};
    endsequence
    ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    ready_one_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    lock_drop_a: assert property (wr_s(ryc_pkg::IDX_YEAR) ##0 !count_unlock && !year_carry
        |=> $stable(year_count)) else $error("year written while locked");
    year_wr_a: assert property (wr_s(ryc_pkg::IDX_YEAR) ##0 count_unlock
        |=> year_count == $past(w_lo)) else $error("year write lost");
    wday_rd_a: assert property (psel && penable && pready && !pwrite
        && paddr == {ryc_pkg::IDX_AWDAY, 2'b00} |-> prdata[31:4] == 28'h0)
        else $error("weekday upper bits not zero");
    irq_flag_a: assert property (alarm_irq |-> alarm_flag)
        else $error("irq without alarm flag");
    flag_cause_a: assert property ($rose(alarm_flag) |-> $past(alarm_enable) != 4'h0)
        else $error("alarm with no field enabled");
    flag_when_a: assert property ($rose(alarm_flag) |-> $past(count_tick)
        || $past(count_tick, 2) || $past(count_unlock) || $past(count_unlock, 2))
        else $error("alarm outside tick or lock");
endmodule : ryc_regs_checker

bind ryc_regs ryc_regs_checker i_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .count_tick, .year_carry, .count_unlock,
    .alarm_enable, .year_count, .alarm_flag, .alarm_irq);

// ---- dv/ryc_regs_tb.sv ----
// Purpose: self-checking bench for ryc_regs
// Assumes: pclk_en high, cur_hour and cur_weekday fixed
// Notes:   each table row unlocks or locks, writes, then reads back
module ryc_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] c; logic [9:0] i; logic [7:0] d, x; logic e;} ryc_row_type;
    localparam ryc_row_type ROWS [11] = '{
        '{8'h21, 10'h0e6, 8'h99, 8'h99, 1'b0},
        '{8'h21, 10'h0e7, 8'h20, 8'h20, 1'b0},
        '{8'h21, 10'h0e8, 8'h59, 8'h59, 1'b0},
        '{8'h21, 10'h0e9, 8'h3b, 8'h3b, 1'b0},
        '{8'h21, 10'h0ea, 8'h23, 8'h23, 1'b0},
        '{8'h21, 10'h0eb, 8'hf7, 8'h07, 1'b0},
        '{8'h00, 10'h0e6, 8'h11, 8'h99, 1'b0},
        '{8'h00, 10'h0e7, 8'h55, 8'h20, 1'b0},
        '{8'h00, 10'h0eb, 8'h03, 8'h07, 1'b0},
        '{8'h00, 10'h0e8, 8'h3b, 8'h3b, 1'b0},
        '{8'h00, 10'h0f0, 8'h12, 8'h00, 1'b1}};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        count_tick, year_carry, decimal_select, count_unlock, alarm_flag, alarm_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  cur_second, cur_minute, year_count, hundred_year_count;
    logic [3:0]  alarm_enable;
    int          errors, num_checks;
    ryc_regs i_dut (.pclk, .presetn, .pclk_en(1'b1), .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .cur_second, .cur_minute,
        .cur_hour(8'h23), .cur_weekday(4'h7), .count_tick, .year_carry, .decimal_select,
        .count_unlock, .alarm_enable, .year_count, .hundred_year_count, .alarm_flag, .alarm_irq);
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] i, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // waits two edges so either status latency is caught
    task pulse(input logic t);
        @(posedge pclk);
        {count_tick, year_carry} <= {t, !t};
        @(posedge pclk);
        {count_tick, year_carry} <= 2'b00;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask : pulse
    task flag(input logic [1:0] x);
        chk({alarm_flag, alarm_irq}, x);
        apb(1'b0, 10'h0ee, 8'h00, rd, er);
        @(negedge pclk);
        chk({rd[0], alarm_flag}, {x[1], 1'b0});
    endtask : flag
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({count_unlock, decimal_select, alarm_enable, alarm_flag, alarm_irq}, 0);
        $display("reset test done");
    endtask : do_reset
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, count_tick, year_carry} = 0;
        {cur_second, cur_minute, errors, num_checks} = {8'h3b, 8'h3b, 64'h0};
        do_reset();
        foreach (ROWS[k])
        begin
            apb(1'b1, 10'h0ed, ROWS[k].c, rd, er);
            apb(1'b1, ROWS[k].i, ROWS[k].d, rd, er);
            apb(1'b0, ROWS[k].i, 8'h00, rd, er);
            chk({er, rd}, {ROWS[k].e, 24'h0, ROWS[k].x});
        end
        $display("table test done");
        apb(1'b1, 10'h0ed, 8'h20, rd, er);
        pulse(1'b0);
        chk({hundred_year_count, year_count}, 16'h2100);
        do_reset();
        chk({hundred_year_count, year_count}, 16'h2100);
        apb(1'b0, 10'h0e8, 8'h00, rd, er);
        chk(rd, 32'h3b);
        apb(1'b1, 10'h0ed, 8'h01, rd, er);
        apb(1'b1, 10'h0e6, 8'h63, rd, er);
        apb(1'b1, 10'h0e7, 8'h49, rd, er);
        apb(1'b1, 10'h0ed, 8'h00, rd, er);
        pulse(1'b0);
        chk({hundred_year_count, year_count}, 16'h4a00);
        $display("year test done");
        apb(1'b1, 10'h0ec, 8'h01, rd, er);
        apb(1'b1, 10'h0ef, 8'h01, rd, er);
        pulse(1'b1);
        flag(2'b11);
        apb(1'b1, 10'h0ef, 8'h00, rd, er);
        pulse(1'b1);
        flag(2'b10);
        apb(1'b1, 10'h0ec, 8'h0f, rd, er);
        cur_minute <= 8'h00;
        pulse(1'b1);
        flag(2'b00);
        @(posedge pclk);
        cur_minute <= 8'h3b;
        pulse(1'b1);
        flag(2'b10);
        apb(1'b1, 10'h0ec, 8'h00, rd, er);
        pulse(1'b1);
        flag(2'b00);
        apb(1'b1, 10'h0ec, 8'h01, rd, er);
        apb(1'b1, 10'h0ed, 8'h01, rd, er);
        pulse(1'b1);
        chk(alarm_flag, 1'b0);
        apb(1'b1, 10'h0ed, 8'h00, rd, er);
        pulse(1'b0);
        flag(2'b10);
        $display("alarm test done");
        end_of_test();
    end
    initial
    begin
        #1000000;
        errors++;
        end_of_test();
    end
endmodule : ryc_regs_tb
